/* rtl/ptec_traffic_counters.sv */
`timescale 1ns/1ps
// Summary of operation
// - crc error tally is 48 bits, read as three 16-bit slices
// - each enabled clock with the crc error input high adds one to the crc tally
// - crc middle slice returns tally bits 31:16
// - crc low slice returns tally bits 15:0
// - crc high slice returns bits 47:32 held at the middle read; its read zeroes tally bits 47:1, bit 0 takes a same-cycle error
// - after the high slice is read, a 48-bit tally holds only a same-cycle increment
// - count rx error rising edges during frames, 16 bits, clear on read
// - count rx error rising edges while idle, 16 bits, clear on read
// - 48-bit tally of transmitted frames, one per enabled clock that the frame strobe is high
// - tx tally read as high 47:32, middle 31:16, low 15:0
// - reading tx high slice zeroes tx tally bits 47:1; bit 0 takes a same-cycle frame strobe
module ptec_traffic_counters (
  input  wire logic                          I_CLK,
  input  wire logic                          I_RST,
  input  wire logic                          I_CE,
  input  wire logic                          I_PSEL,
  input  wire logic                          I_PENABLE,
  input  wire logic                          I_PWRITE,
  input  wire logic [ptec_pkg::ADDR_W-1:0]   I_PADDR,
  input  wire logic [ptec_pkg::DATA_W-1:0]   I_PWDATA,
  input  wire logic [3:0]                    I_PSTRB,
  output logic      [ptec_pkg::DATA_W-1:0]   O_PRDATA,
  output logic                               O_PREADY,
  output logic                               O_PSLVERR,
  input  wire logic                          I_CRC_ERR,
  input  wire logic                          I_TX_FRAME,
  input  wire logic                          I_RX_ER,
  input  wire logic                          I_RX_DV,
  output logic                               O_IRQ
);
  import ptec_pkg::*;

  logic                rx_er_s1;
  logic                rx_er_s2;
  logic                rx_er_d;
  logic                rx_dv_s1;
  logic                rx_dv_s2;
  logic                er_rise;
  logic                evt_rxd;
  logic                evt_rxi;
  logic                apb_setup;
  logic                apb_acc;
  logic                rd_setup;
  logic                rd_done;
  logic                wr_done;
  logic [SLICE_W-1:0]  rxd_cnt;
  logic [SLICE_W-1:0]  rxi_cnt;
  logic                rxd_rd;
  logic                rxi_rd;
  logic [EVT_N-1:0]    int_stat;
  logic [EVT_N-1:0]    int_mask;
  logic [EVT_N-1:0]    evt_vec;
  logic [EVT_N-1:0]    w1c;
  logic [EVT_N-1:0]    next_int_stat;
  logic [DATA_W-1:0]   next_rdata;
  logic [SLICE_W-1:0]  crc_mid_live;
  logic [SLICE_W-1:0]  crc_low_live;
  logic [SLICE_W-1:0]  tx_low_live;

  ptec_tally_if #(.W(TALLY_W)) crc_bus ();
  ptec_tally_if #(.W(TALLY_W)) tx_bus ();

  // rx pins come from another domain
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rx_er_s1 <= 1'b0;
      rx_er_s2 <= 1'b0;
      rx_er_d  <= 1'b0;
      rx_dv_s1 <= 1'b0;
      rx_dv_s2 <= 1'b0;
    end else if (I_CE) begin
      rx_er_s1 <= I_RX_ER;
      rx_er_s2 <= rx_er_s1;
      rx_er_d  <= rx_er_s2;
      rx_dv_s1 <= I_RX_DV;
      rx_dv_s2 <= rx_dv_s1;
    end
  end

  assign er_rise = rx_er_s2 & ~rx_er_d;
  assign evt_rxd = er_rise & rx_dv_s2;
  assign evt_rxi = er_rise & ~rx_dv_s2;

  // apb phases, zero wait states while enabled
  assign O_PREADY  = I_CE;
  assign apb_setup = I_PSEL & ~I_PENABLE & I_CE;
  assign apb_acc   = I_PSEL & I_PENABLE & I_CE;
  assign rd_setup  = apb_setup & ~I_PWRITE;
  assign rd_done   = apb_acc & ~I_PWRITE;
  assign wr_done   = apb_acc & I_PWRITE;
  assign O_PSLVERR = I_PSEL & I_PENABLE & ~ptec_mapped(I_PADDR);

  assign crc_bus.inc  = I_CRC_ERR;
  assign crc_bus.snap = rd_setup && (I_PADDR == OFS_CRC_MID);
  assign crc_bus.clr  = rd_done && (I_PADDR == OFS_CRC_HIGH);

  assign tx_bus.inc  = I_TX_FRAME;
  assign tx_bus.snap = rd_setup && (I_PADDR == OFS_TX_LOW);
  assign tx_bus.clr  = rd_done && (I_PADDR == OFS_TX_HIGH);

  ptec_tally48 #(.W(TALLY_W)) u_crc (
    .i_clk (I_CLK),
    .i_rst (I_RST),
    .i_ce  (I_CE),
    .bus   (crc_bus)
  );

  ptec_tally48 #(.W(TALLY_W)) u_tx (
    .i_clk (I_CLK),
    .i_rst (I_RST),
    .i_ce  (I_CE),
    .bus   (tx_bus)
  );

  assign rxd_rd = rd_done && (I_PADDR == OFS_RXD);
  assign rxi_rd = rd_done && (I_PADDR == OFS_RXI);

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rxd_cnt <= RST_SLICE;
    end else if (I_CE) begin
      if (rxd_rd) begin
        rxd_cnt <= {15'h0000, evt_rxd};
      end else if (evt_rxd) begin
        rxd_cnt <= rxd_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rxi_cnt <= RST_SLICE;
    end else if (I_CE) begin
      if (rxi_rd) begin
        rxi_cnt <= {15'h0000, evt_rxi};
      end else if (evt_rxi) begin
        rxi_cnt <= rxi_cnt + 16'h0001;
      end
    end
  end

  // interrupt status, set wins over write-one-clear
  always_comb begin
    evt_vec = RST_EVT;
    evt_vec[EVT_CRC] = I_CRC_ERR;
    evt_vec[EVT_RXD] = evt_rxd;
    evt_vec[EVT_RXI] = evt_rxi;
    evt_vec[EVT_TX]  = I_TX_FRAME;
    w1c = RST_EVT;
    if (wr_done && (I_PADDR == OFS_INT_STAT) && I_PSTRB[0]) begin
      w1c = I_PWDATA[EVT_N-1:0];
    end
    next_int_stat = (int_stat & ~w1c) | evt_vec;
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      int_stat <= RST_EVT;
    end else if (I_CE) begin
      int_stat <= next_int_stat;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      int_mask <= RST_EVT;
    end else if (wr_done && (I_PADDR == OFS_INT_MASK) && I_PSTRB[0]) begin
      int_mask <= I_PWDATA[EVT_N-1:0];
    end
  end

  assign O_IRQ = |(int_stat & int_mask);

  assign crc_mid_live = ptec_slice(crc_bus.live, MID_LSB);
  assign crc_low_live = ptec_slice(crc_bus.live, LOW_LSB);
  assign tx_low_live  = ptec_slice(tx_bus.live, LOW_LSB);

  // read data mux, sampled in the setup phase
  always_comb begin
    next_rdata = RST_WORD;
    case (I_PADDR)
      OFS_CRC_HIGH: next_rdata = ptec_word16(
                      ptec_slice(crc_bus.held, HIGH_LSB));
      OFS_CRC_MID:  next_rdata = ptec_word16(crc_mid_live);
      OFS_CRC_LOW:  next_rdata = ptec_word16(crc_low_live);
      OFS_RXD:      next_rdata = ptec_word16(rxd_cnt);
      OFS_RXI:      next_rdata = ptec_word16(rxi_cnt);
      // tx slices, upper two from snapshot
      OFS_TX_HIGH:  next_rdata = ptec_word16(
                      ptec_slice(tx_bus.held, HIGH_LSB));
      OFS_TX_MID:   next_rdata = ptec_word16(
                      ptec_slice(tx_bus.held, MID_LSB));
      OFS_TX_LOW:   next_rdata = ptec_word16(tx_low_live);
      OFS_INT_STAT: next_rdata = {28'h0000000, int_stat};
      OFS_INT_MASK: next_rdata = {28'h0000000, int_mask};
      default:      next_rdata = RST_WORD;
    endcase
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_PRDATA <= RST_WORD;
    end else if (rd_setup) begin
      O_PRDATA <= next_rdata;
    end
  end

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  property p_crc_inc;
    I_CE && I_CRC_ERR && !crc_bus.clr |=>
      crc_bus.live == $past(crc_bus.live) + 48'h0000_0000_0001;
  endproperty
  a_crc_inc: assert property (p_crc_inc)
    else $error("crc tally missed an error");

  property p_crc_mid;
    rd_setup && I_PADDR == OFS_CRC_MID |=>
      O_PRDATA == {16'h0000, $past(crc_mid_live)};
  endproperty
  a_crc_mid: assert property (p_crc_mid)
    else $error("crc middle slice wrong");

  property p_crc_low;
    rd_setup && I_PADDR == OFS_CRC_LOW |=>
      O_PRDATA == {16'h0000, $past(crc_low_live)};
  endproperty
  a_crc_low: assert property (p_crc_low)
    else $error("crc low slice wrong");

  property p_crc_clr;
    rd_done && I_PADDR == OFS_CRC_HIGH && !I_CRC_ERR |=>
      crc_bus.live == RST_TALLY;
  endproperty
  a_crc_clr: assert property (p_crc_clr)
    else $error("crc tally not cleared by high read");

  property p_rxd_cnt;
    I_CE && $rose(rx_er_s2) && rx_dv_s2 && !rxd_rd |=>
      rxd_cnt == 16'($past(rxd_cnt) + 16'h0001);
  endproperty
  a_rxd_cnt: assert property (p_rxd_cnt)
    else $error("in-frame rx error not counted");

  property p_rxi_cnt;
    I_CE && $rose(rx_er_s2) && !rx_dv_s2 && !rxi_rd && !rxd_rd ##1 1 |->
      rxi_cnt == 16'($past(rxi_cnt) + 16'h0001) && $stable(rxd_cnt);
  endproperty
  a_rxi_cnt: assert property (p_rxi_cnt)
    else $error("idle rx error not counted");

  property p_tx_inc;
    I_CE && I_TX_FRAME && !tx_bus.clr |=>
      tx_bus.live == $past(tx_bus.live) + 48'h0000_0000_0001;
  endproperty
  a_tx_inc: assert property (p_tx_inc)
    else $error("tx tally missed a frame");

  property p_tx_snap;
    rd_setup && I_PADDR == OFS_TX_LOW |=>
      tx_bus.held == $past(tx_bus.live) &&
      O_PRDATA == {16'h0000, $past(tx_low_live)};
  endproperty
  a_tx_snap: assert property (p_tx_snap)
    else $error("tx snapshot not taken on low read");

  property p_tx_clr;
    rd_done && I_PADDR == OFS_TX_HIGH && !I_TX_FRAME |=>
      tx_bus.live == RST_TALLY;
  endproperty
  a_tx_clr: assert property (p_tx_clr)
    else $error("tx tally not cleared by high read");

  c_crc_order: cover property (rd_done && I_PADDR == OFS_CRC_MID
    ##[1:20] rd_done && I_PADDR == OFS_CRC_HIGH);
  c_tx_clear: cover property (tx_bus.clr && tx_bus.live != RST_TALLY);
  c_irq_rise: cover property ($rose(O_IRQ));
  c_rx_both: cover property (evt_rxd ##[1:50] evt_rxi);
endmodule

/* rtl/ptec_pkg.sv */
package ptec_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int TALLY_W = 48;
  localparam int SLICE_W = 16;
  localparam int EVT_N = 4;

  localparam logic [ADDR_W-1:0] OFS_CRC_HIGH  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CRC_MID   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CRC_LOW   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RXD       = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_RXI       = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_TX_HIGH   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_TX_MID    = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_TX_LOW    = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_INT_STAT  = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_INT_MASK  = 8'h24;

  localparam int HIGH_LSB = 32;
  localparam int MID_LSB  = 16;
  localparam int LOW_LSB  = 0;

  localparam int EVT_CRC = 0;
  localparam int EVT_RXD = 1;
  localparam int EVT_RXI = 2;
  localparam int EVT_TX  = 3;

  localparam logic [TALLY_W-1:0] RST_TALLY = 48'h0000_0000_0000;
  localparam logic [SLICE_W-1:0] RST_SLICE = 16'h0000;
  localparam logic [EVT_N-1:0]   RST_EVT   = 4'h0;
  localparam logic [DATA_W-1:0]  RST_WORD  = 32'h0000_0000;

  // zero-extends a slice into a bus word
  function automatic logic [DATA_W-1:0] ptec_word16(
    input logic [SLICE_W-1:0] v);
    return {16'h0000, v};
  endfunction

  // picks one 16-bit slice of a tally
  function automatic logic [SLICE_W-1:0] ptec_slice(
    input logic [TALLY_W-1:0] v,
    input int                 lsb);
    return v[lsb +: SLICE_W];
  endfunction

  function automatic logic ptec_mapped(input logic [ADDR_W-1:0] a);
    return (a == OFS_CRC_HIGH) || (a == OFS_CRC_MID) ||
           (a == OFS_CRC_LOW) || (a == OFS_RXD) || (a == OFS_RXI) ||
           (a == OFS_TX_HIGH) || (a == OFS_TX_MID) ||
           (a == OFS_TX_LOW) || (a == OFS_INT_STAT) ||
           (a == OFS_INT_MASK);
  endfunction

endpackage

/* rtl/ptec_tally_if.sv */
`timescale 1ns/1ps
interface ptec_tally_if #(
  parameter int W = 48
);
  logic         inc;
  logic         snap;
  logic         clr;
  logic [W-1:0] live;
  logic [W-1:0] held;

  modport ctl (output inc, output snap, output clr,
               input live, input held);
  modport tly (input inc, input snap, input clr,
               output live, output held);
endinterface

/* rtl/ptec_tally48.sv */
`timescale 1ns/1ps
module ptec_tally48 #(
  parameter int W = 48
) (
  input wire logic   i_clk,
  input wire logic   i_rst,
  input wire logic   i_ce,
  ptec_tally_if.tly  bus
);
  logic [W-1:0] cnt;
  logic [W-1:0] snap_q;

  assign bus.live = cnt;
  assign bus.held = snap_q;

  // counting with clear, clear wins and keeps a same-cycle increment
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt <= '0;
    end else if (i_ce) begin
      if (bus.clr) begin
        cnt <= {{(W-1){1'b0}}, bus.inc};
      end else if (bus.inc) begin
        cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      snap_q <= '0;
    end else if (i_ce && bus.snap) begin
      snap_q <= cnt;
    end
  end

  property p_tally_clear;
    @(posedge i_clk) disable iff (i_rst)
      i_ce && bus.clr && !bus.inc |=> cnt == '0;
  endproperty
  a_tally_clear: assert property (p_tally_clear)
    else $error("tally not zero after clear");

  property p_tally_hold;
    @(posedge i_clk) disable iff (i_rst)
      !i_ce |=> cnt == $past(cnt) && snap_q == $past(snap_q);
  endproperty
  a_tally_hold: assert property (p_tally_hold)
    else $error("tally moved while clock enable low");
endmodule

/* tb/ptec_traffic_counters_bench.sv */
`timescale 1ns/1ps
module ptec_traffic_counters_bench;
  import ptec_pkg::*;

  logic              clk;
  logic              rst;
  logic              ce;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              crc_err;
  logic              tx_frame;
  logic              rx_er;
  logic              rx_dv;
  logic              irq;
  logic [DATA_W-1:0] rd_q;
  logic              err_q;
  logic [ADDR_W-1:0] addr_tab [0:9];
  int                n_mismatch;
  int                check_count;

  ptec_traffic_counters i_dut (
    .I_CLK     (clk),
    .I_RST     (rst),
    .I_CE      (ce),
    .I_PSEL    (psel),
    .I_PENABLE (penable),
    .I_PWRITE  (pwrite),
    .I_PADDR   (paddr),
    .I_PWDATA  (pwdata),
    .I_PSTRB   (4'hF),
    .O_PRDATA  (prdata),
    .O_PREADY  (pready),
    .O_PSLVERR (pslverr),
    .I_CRC_ERR (crc_err),
    .I_TX_FRAME(tx_frame),
    .I_RX_ER   (rx_er),
    .I_RX_DV   (rx_dv),
    .O_IRQ     (irq)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic print_verdict;
    $display("mismatches %0d, comparisons %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input logic [DATA_W-1:0] got,
                     input logic [DATA_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer: setup, access until pready, then release
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, pready, 1'b1);
    end
    rd_q  = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    cmp(rd_q, exp);
    cmp({31'h0000_0000, err_q}, 32'h0000_0000);
  endtask

  // pulses: which 0 = crc error, 1 = transmitted frame
  task automatic pulse(input int which, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      if (which == 0) begin
        crc_err <= 1'b1;
      end else begin
        tx_frame <= 1'b1;
      end
      @(posedge clk);
      crc_err  <= 1'b0;
      tx_frame <= 1'b0;
    end
  endtask

  // holds the frame strobe high for n edges in a row
  task automatic tx_hold(input int n);
    @(posedge clk);
    tx_frame <= 1'b1;
    repeat (n) @(posedge clk);
    tx_frame <= 1'b0;
  endtask

  task automatic rx_edge(input logic dv);
    @(posedge clk);
    rx_dv <= dv;
    repeat (5) @(posedge clk);
    rx_er <= 1'b1;
    repeat (5) @(posedge clk);
    rx_er <= 1'b0;
    repeat (5) @(posedge clk);
  endtask

  task automatic irq_chk(input logic exp);
    @(negedge clk);
    cmp({31'h0000_0000, irq}, {31'h0000_0000, exp});
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    print_verdict;
  end

  initial begin
    addr_tab = '{OFS_CRC_HIGH, OFS_CRC_MID, OFS_CRC_LOW, OFS_RXD, OFS_RXI,
                 OFS_TX_HIGH, OFS_TX_MID, OFS_TX_LOW, OFS_INT_STAT,
                 OFS_INT_MASK};
    n_mismatch  = 0;
    check_count = 0;
    rst      = 1'b1;
    ce       = 1'b1;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 8'h00;
    pwdata   = 32'h0000_0000;
    crc_err  = 1'b0;
    tx_frame = 1'b0;
    rx_er    = 1'b0;
    rx_dv    = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 10; k++) begin
      rd_chk(addr_tab[k], 32'h0000_0000);
    end
    irq_chk(1'b0);
    apb(1'b0, 8'h28, 32'h0000_0000);
    cmp({31'h0000_0000, err_q}, 32'h0000_0001);
    apb(1'b1, OFS_CRC_LOW, 32'h0000_FFFF);
    rd_chk(OFS_CRC_LOW, 32'h0000_0000);
    pulse(0, 5);
    rd_chk(OFS_CRC_MID, 32'h0000_0000);
    rd_chk(OFS_CRC_HIGH, 32'h0000_0000);
    rd_chk(OFS_CRC_LOW, 32'h0000_0000);
    pulse(0, 7);
    rd_chk(OFS_CRC_LOW, 32'h0000_0007);
    rd_chk(OFS_CRC_LOW, 32'h0000_0007);
    rd_chk(OFS_CRC_MID, 32'h0000_0000);
    rd_chk(OFS_CRC_HIGH, 32'h0000_0000);
    rd_chk(OFS_CRC_LOW, 32'h0000_0000);
    ce <= 1'b0;
    pulse(0, 3);
    ce <= 1'b1;
    rd_chk(OFS_CRC_LOW, 32'h0000_0000);
    pulse(1, 3);
    rd_chk(OFS_TX_LOW, 32'h0000_0003);
    pulse(1, 2);
    rd_chk(OFS_TX_MID, 32'h0000_0000);
    rd_chk(OFS_TX_HIGH, 32'h0000_0000);
    rd_chk(OFS_TX_LOW, 32'h0000_0000);
    pulse(1, 1);
    rd_chk(OFS_TX_LOW, 32'h0000_0001);
    rd_chk(OFS_TX_MID, 32'h0000_0000);
    rd_chk(OFS_TX_HIGH, 32'h0000_0000);
    rd_chk(OFS_TX_LOW, 32'h0000_0000);
    tx_hold(65535);
    rd_chk(OFS_TX_LOW, 32'h0000_FFFF);
    pulse(1, 2);
    rd_chk(OFS_TX_MID, 32'h0000_0000);
    rd_chk(OFS_TX_LOW, 32'h0000_0001);
    rd_chk(OFS_TX_MID, 32'h0000_0001);
    rd_chk(OFS_TX_HIGH, 32'h0000_0000);
    rd_chk(OFS_TX_LOW, 32'h0000_0000);
    rx_edge(1'b1);
    rx_edge(1'b1);
    rx_edge(1'b0);
    rd_chk(OFS_RXD, 32'h0000_0002);
    rd_chk(OFS_RXD, 32'h0000_0000);
    rd_chk(OFS_RXI, 32'h0000_0001);
    rd_chk(OFS_RXI, 32'h0000_0000);
    rd_chk(OFS_INT_STAT, 32'h0000_000F);
    irq_chk(1'b0);
    apb(1'b1, OFS_INT_MASK, 32'h0000_0001);
    irq_chk(1'b1);
    apb(1'b1, OFS_INT_STAT, 32'h0000_0001);
    irq_chk(1'b0);
    rd_chk(OFS_INT_STAT, 32'h0000_000E);
    apb(1'b1, OFS_INT_MASK, 32'h0000_000F);
    rd_chk(OFS_INT_MASK, 32'h0000_000F);
    irq_chk(1'b1);
    apb(1'b1, OFS_INT_STAT, 32'h0000_000F);
    irq_chk(1'b0);
    rd_chk(OFS_INT_STAT, 32'h0000_0000);
    print_verdict;
  end
endmodule
